// ===== design/cem_mux_ctrl.sv
// client encapsulation mux: n host lanes mapped in fixed order into one
// network slot word, demapped on receive, with squelch and replacement.
// assumes host and network samples are synchronous to clk and that the
// host keeps one lane rate and lane order matching the structure.
`timescale 1ns/1ps
`default_nettype none
module cem_mux_ctrl
	import cem_pkg::*;
(
	input wire logic clk, // 20 mhz system clock
	input wire logic rst, // synchronous, active high
	input wire logic [cem_pkg::ADDR_W-1:0] reg_addr, // register address
	input wire logic [cem_pkg::DATA_W-1:0] reg_wdata, // write data
	input wire logic reg_we, // write strobe
	input wire logic reg_re, // read strobe
	output logic [cem_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
	input wire logic [cem_pkg::NET_W-1:0] tx_host_data, // host lanes in
	input wire logic [cem_pkg::NUM_PATHS-1:0] tx_host_valid, // host sample present
	output logic [cem_pkg::NET_W-1:0] tx_net_data, // network slot word
	output logic [cem_pkg::NUM_PATHS-1:0] tx_net_stuff, // slot carries no payload
	output logic [cem_pkg::NUM_PATHS-1:0] tx_net_squelch, // slot forcibly squelched
	input wire logic [cem_pkg::NET_W-1:0] rx_net_data, // received slot word
	input wire logic [cem_pkg::NUM_PATHS-1:0] rx_net_stuff, // received stuff marks
	input wire logic loss_of_network_signal, // media signal lost
	input wire logic [cem_pkg::NUM_PATHS-1:0] rx_host_fail, // digital rx path fail
	output logic [cem_pkg::NET_W-1:0] rx_host_data, // host lanes out
	output logic [cem_pkg::NUM_PATHS-1:0] rx_host_valid, // host sample present
	output logic [cem_pkg::NUM_PATHS-1:0] rx_output_valid_indicator, // lane output valid
	output logic [cem_pkg::NUM_PATHS-1:0] rx_host_squelch // lane output squelched
);
	import cem_pkg::*;

	// ==========================================================
	// control registers
	// every field is a level written whole by software; hardware never
	// clears one, so no set-against-clear race can arise
	logic [NUM_PATHS-1:0] path_en_reg; // host path init requests
	logic net_en_reg; // network path init request
	logic [NUM_PATHS-1:0] tx_repl_reg; // tx replacement enables
	logic [NUM_PATHS-1:0] rx_repl_reg; // rx replacement enables
	logic [NUM_PATHS-1:0] tx_force_reg; // tx forced squelch
	logic [NUM_PATHS-1:0] rx_force_reg; // rx forced squelch
	logic rx_auto_squelch_disable; // rx auto squelch off
	logic [DATA_W-1:0] rdata_reg; // read data holder
	cem_path_t path_state_reg [NUM_PATHS]; // one machine per host path
	cem_net_t net_state_reg; // network side state machine
	cem_net_t net_state_next;

	// address decode: exact byte match; a write to an unmapped address
	// simply matches nothing and is dropped without a response
	wire logic wr_ctrl = reg_we && (reg_addr == ADDR_CTRL);
	wire logic wr_txr = reg_we && (reg_addr == ADDR_TX_REPL);
	wire logic wr_rxr = reg_we && (reg_addr == ADDR_RX_REPL);
	wire logic wr_sq = reg_we && (reg_addr == ADDR_SQUELCH);
	wire logic rx_auto_squelch_disable_capability = ASQ_DIS_CAPABLE;
	wire logic net_up = (net_state_reg == net_initialized);
	// driven bit by bit from the generate loop, hence a net
	wire logic [NUM_PATHS-1:0] path_up; // per path initialized flags

	// ==========================================================
	// register writes
	// strobes may come back to back; each write replaces its whole field
	always_ff @(posedge clk) begin
		if (rst) begin
			path_en_reg <= RST_ENABLES;
			net_en_reg <= RST_FLAG;
			tx_repl_reg <= RST_ENABLES;
			rx_repl_reg <= RST_ENABLES;
			tx_force_reg <= RST_ENABLES;
			rx_force_reg <= RST_ENABLES;
			rx_auto_squelch_disable <= RST_FLAG;
		end else begin
			// network enable shares the ctrl word, so every path edit rewrites it from CTRL_NET_BIT
			if (wr_ctrl) begin
				path_en_reg <= reg_wdata[NUM_PATHS-1:0];
				net_en_reg <= reg_wdata[CTRL_NET_BIT];
			end
			// replacement enables only arm the selectors; network gates tx replacement, path gates rx replacement
			if (wr_txr) begin
				tx_repl_reg <= reg_wdata[NUM_PATHS-1:0];
			end
			if (wr_rxr) begin
				rx_repl_reg <= reg_wdata[NUM_PATHS-1:0];
			end
			// one word holds tx forced, rx forced and the auto squelch disable
			if (wr_sq) begin
				tx_force_reg <= reg_wdata[NUM_PATHS-1:0];
				rx_force_reg <= reg_wdata[SQ_RX_LSB +: NUM_PATHS];
				rx_auto_squelch_disable <= reg_wdata[SQ_ASQ_DIS_BIT];
			end
		end
	end

	// ==========================================================
	// read mux: unmapped addresses and idle cycles read zero
	// status fields are live views taken at the edge of the read strobe
	wire logic [DATA_W-1:0] status_word = {{(DATA_W-ST_CAP_BIT-1){1'b0}},
		rx_auto_squelch_disable_capability, {(ST_CAP_BIT-ST_OVI_LSB-NUM_PATHS){1'b0}},
		rx_output_valid_indicator, {(ST_OVI_LSB-ST_NET_BIT-1){1'b0}}, net_up, path_up};
	wire logic [DATA_W-1:0] rd_mux =
		(reg_addr == ADDR_CTRL) ? {{(DATA_W-CTRL_NET_BIT-1){1'b0}}, net_en_reg,
			path_en_reg} :
		(reg_addr == ADDR_TX_REPL) ? {{(DATA_W-NUM_PATHS){1'b0}}, tx_repl_reg} :
		(reg_addr == ADDR_RX_REPL) ? {{(DATA_W-NUM_PATHS){1'b0}}, rx_repl_reg} :
		(reg_addr == ADDR_SQUELCH) ? {{(DATA_W-SQ_ASQ_DIS_BIT-1){1'b0}},
			rx_auto_squelch_disable, rx_force_reg, tx_force_reg} :
		(reg_addr == ADDR_STATUS) ? status_word : '0;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_re ? rd_mux : '0;
		end
	end
	assign reg_rdata = rdata_reg;

	// ==========================================================
	// network side state machine: follows its own enable only
	// no host input reaches this machine, which is what keeps the network
	// signal running through host path edits
	always_comb begin
		unique case (net_state_reg)
			net_deactivated: net_state_next = net_en_reg ? net_initialized : net_deactivated;
			net_initialized: net_state_next = net_en_reg ? net_initialized : net_deactivated;
		endcase
	end

	// host presence plays no part, so the network stays up without hosts
	always_ff @(posedge clk) begin
		if (rst) begin
			net_state_reg <= net_deactivated;
		end else begin
			net_state_reg <= net_state_next;
		end
	end

	// ==========================================================
	// per host path: state machine, tx mapping and rx demapping.
	// path i is named by its lowest host lane, i * LANES_PER_PATH.
	// every lane shares LANE_W and the clk slot rate, so one lane rate.
	// the slot rate is the clk rate; stuffing against a truly asynchronous
	// host clock would need a per-lane buffer, which this block leaves out.
	genvar i;
	generate
		for (i = 0; i < NUM_PATHS; i++) begin : g_path
			localparam int LO = i * LANE_W; // slot position, fixed order
			wire logic host_ok = path_up[i] && net_up && tx_host_valid[i];
			wire logic auto_sq = !rx_auto_squelch_disable
				&& (loss_of_network_signal || rx_host_fail[i]);
			wire logic rx_repl_on = rx_repl_reg[i] && path_up[i];
			wire logic rx_fwd_on = path_up[i] && net_up && !auto_sq;
			// tx select: forced, replacement, forward; no auto squelch here
			wire logic [LANE_W-1:0] tx_d_next = tx_force_reg[i] ? IDLE_BYTE :
				(tx_repl_reg[i] && net_up) ? REPL_PATTERN :
				host_ok ? tx_host_data[LO +: LANE_W] : IDLE_BYTE;
			wire logic tx_s_next = tx_force_reg[i] ||
				!((tx_repl_reg[i] && net_up) || host_ok);
			// rx select: forced, replacement, auto squelch, forward
			wire logic [LANE_W-1:0] rx_d_next = rx_force_reg[i] ? IDLE_BYTE :
				rx_repl_on ? REPL_PATTERN :
				rx_fwd_on ? rx_net_data[LO +: LANE_W] : IDLE_BYTE;
			wire logic rx_ovi_next = !rx_force_reg[i] && (rx_repl_on || rx_fwd_on);

			assign path_up[i] = (path_state_reg[i] == path_initialized_state);

			// no transient states: down or up, one cycle after the enable
			// two-state machine touching only this host segment
			always_ff @(posedge clk) begin
				if (rst) begin
					path_state_reg[i] <= path_deactivated_state;
				end else if (path_en_reg[i]) begin
					path_state_reg[i] <= path_initialized_state;
				end else begin
					path_state_reg[i] <= path_deactivated_state;
				end
			end

			// forced squelch also raises the stuff mark, so the slot reads empty
			// tx slot i holds lane i; no crossbar exists
			always_ff @(posedge clk) begin
				if (rst) begin
					tx_net_data[LO +: LANE_W] <= IDLE_BYTE;
					tx_net_stuff[i] <= 1'b1;
					tx_net_squelch[i] <= 1'b0;
				end else begin
					tx_net_data[LO +: LANE_W] <= tx_d_next;
					tx_net_stuff[i] <= tx_s_next;
					tx_net_squelch[i] <= tx_force_reg[i];
				end
			end

			// the squelch output is the plain inverse of the output valid indicator
			// rx lane i takes slot i; stuffed slots give no host sample
			always_ff @(posedge clk) begin
				if (rst) begin
					rx_host_data[LO +: LANE_W] <= IDLE_BYTE;
					rx_host_valid[i] <= 1'b0;
					rx_output_valid_indicator[i] <= 1'b0;
					rx_host_squelch[i] <= 1'b1;
				end else begin
					rx_host_data[LO +: LANE_W] <= rx_d_next;
					rx_host_valid[i] <= !rx_force_reg[i] && (rx_repl_on
						|| (rx_fwd_on && !rx_net_stuff[i]));
					rx_output_valid_indicator[i] <= rx_ovi_next;
					rx_host_squelch[i] <= !rx_ovi_next;
				end
			end
		end
	endgenerate

	// ==========================================================
	// assertions: every lane is one generate body, so a check on one lane
	// stands for the same logic on every other lane
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// forced tx squelch empties the slot one cycle later
	chk_tx_force_squelch: assert property (
		tx_force_reg[0] |=> tx_net_stuff[0] && tx_net_data[LANE_W-1:0] == IDLE_BYTE)
		else $error("forced tx squelch not applied");

	// host or network defects never empty a live tx slot
	chk_tx_no_auto: assert property (
		(loss_of_network_signal && rx_host_fail[0] && !tx_force_reg[0] && net_up
		&& path_up[0] && tx_host_valid[0]) |=> !tx_net_stuff[0])
		else $error("tx slot squelched by a host defect");

	// lane 1 lands in slot 1, one cycle late
	chk_tx_map_order: assert property (
		(net_up && path_up[1] && tx_host_valid[1] && !tx_force_reg[1] && !tx_repl_reg[1])
		|=> tx_net_data[2*LANE_W-1:LANE_W] == $past(tx_host_data[2*LANE_W-1:LANE_W]))
		else $error("lane 1 not in slot 1");

	// tx replacement fills the slot with the pattern
	chk_tx_repl_insert: assert property (
		(tx_repl_reg[0] && net_up && !tx_force_reg[0])
		|=> tx_net_data[LANE_W-1:0] == REPL_PATTERN && !tx_net_stuff[0])
		else $error("tx replacement missing");

	// rx replacement survives loss of the network signal
	chk_rx_repl_prio: assert property (
		(rx_repl_reg[0] && path_up[0] && !rx_force_reg[0] && loss_of_network_signal)
		|=> rx_output_valid_indicator[0] && rx_host_data[LANE_W-1:0] == REPL_PATTERN)
		else $error("auto squelch overrode replacement");

	// loss squelches the rx lane unless replacement runs
	chk_rx_auto_squelch: assert property (
		(loss_of_network_signal && !rx_auto_squelch_disable && !rx_repl_reg[0])
		|=> rx_host_squelch[0] && !rx_output_valid_indicator[0])
		else $error("rx not squelched on loss");

	// disabled auto squelch keeps forwarding through loss
	chk_rx_asq_disable: assert property (
		(rx_auto_squelch_disable && loss_of_network_signal && path_up[0] && net_up
		&& !rx_force_reg[0]) |=> rx_output_valid_indicator[0])
		else $error("auto squelch disable ignored");

	// slot 1 comes out on lane 1, one cycle late
	chk_rx_demap_lane: assert property (
		(net_up && path_up[1] && !rx_force_reg[1] && !rx_repl_reg[1]
		&& !loss_of_network_signal && !rx_host_fail[1])
		|=> rx_host_data[2*LANE_W-1:LANE_W] == $past(rx_net_data[2*LANE_W-1:LANE_W]))
		else $error("rx slot 1 not demapped to lane 1");

	// path edits leave the network up
	chk_net_continuity: assert property (
		(net_up && net_en_reg && $changed(path_en_reg)) |=> net_up [*2])
		else $error("network disturbed by path change");

	// a path without enable falls back to deactivated
	chk_path_states: assert property (
		!path_en_reg[0] |=> path_state_reg[0] == path_deactivated_state)
		else $error("path left active without enable");

	// network comes up with no host path at all
	chk_net_alone: assert property (
		(net_en_reg && path_en_reg == '0) |=> net_up)
		else $error("network held down without host paths");

	// capability bit always reads back in the status word
	chk_status_cap: assert property (
		(reg_re && reg_addr == ADDR_STATUS)
		|=> reg_rdata[ST_CAP_BIT] == rx_auto_squelch_disable_capability)
		else $error("auto squelch disable capability not shown");

	// an absent host sample leaves a stuffed idle slot
	chk_tx_stuff_absent: assert property (
		(!tx_host_valid[2] && !tx_force_reg[2] && !tx_repl_reg[2])
		|=> tx_net_stuff[2] && tx_net_data[3*LANE_W-1:2*LANE_W] == IDLE_BYTE)
		else $error("absent host lane not stuffed");

	// a stuffed rx slot gives no sample but keeps the lane valid
	chk_rx_stuff_gap: assert property (
		(net_up && path_up[2] && !rx_force_reg[2] && !rx_repl_reg[2]
		&& !loss_of_network_signal && !rx_host_fail[2] && rx_net_stuff[2])
		|=> !rx_host_valid[2] && rx_output_valid_indicator[2])
		else $error("stuffed rx slot mishandled");

	// a digital rx path fail squelches only its own lane
	chk_rx_fail_lane: assert property (
		(rx_host_fail[1] && !rx_auto_squelch_disable && !rx_repl_reg[1])
		|=> !rx_output_valid_indicator[1] && rx_host_data[2*LANE_W-1:LANE_W] == IDLE_BYTE)
		else $error("rx lane fail not squelched");

	// forced rx squelch wins over everything
	chk_rx_force_lane: assert property (
		rx_force_reg[0]
		|=> rx_host_squelch[0] && !rx_host_valid[0] && rx_host_data[LANE_W-1:0] == IDLE_BYTE)
		else $error("forced rx squelch not applied");

	// rx replacement is a valid output and raises the indicator
	chk_rx_repl_valid: assert property (
		(rx_repl_reg[0] && path_up[0] && !rx_force_reg[0])
		|=> rx_output_valid_indicator[0] && rx_host_valid[0] && !rx_host_squelch[0])
		else $error("rx replacement not marked valid");

	// forced squelch beats tx replacement
	chk_tx_force_repl: assert property (
		(tx_force_reg[3] && tx_repl_reg[3])
		|=> tx_net_squelch[3] && tx_net_data[4*LANE_W-1:3*LANE_W] == IDLE_BYTE)
		else $error("tx replacement beat forced squelch");

	// main scenarios
	cov_rx_replacement: cover property (rx_repl_reg[0] ##1 rx_output_valid_indicator[0]);
	cov_loss_squelch: cover property (loss_of_network_signal ##1 rx_host_squelch[0]);
	cov_path_change: cover property (net_up && $changed(path_en_reg) ##2 net_up);
	cov_tx_replacement: cover property (tx_repl_reg[0] && net_up ##1 !tx_net_stuff[0]);
	cov_rx_stuff_gap: cover property (rx_net_stuff[2] && net_up ##1 !rx_host_valid[2]);
endmodule
`default_nettype wire

// ===== design/cem_pkg.sv
// constants, register map and state types of the client encapsulation mux
// assumes one clock domain and a plain register port with one-cycle read data
package cem_pkg;
	// ==========================================================
	// structure
	localparam int NUM_PATHS = 4; // host paths in the n:1 structure
	localparam int LANES_PER_PATH = 1; // host lanes per host path
	localparam int LANE_W = 8; // identical per-lane data width
	localparam int NET_W = NUM_PATHS * LANE_W; // network slot word
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00; // path and network enables
	localparam logic [7:0] ADDR_TX_REPL = 8'h04; // tx replacement enables
	localparam logic [7:0] ADDR_RX_REPL = 8'h08; // rx replacement enables
	localparam logic [7:0] ADDR_SQUELCH = 8'h0c; // forced squelch, auto disable
	localparam logic [7:0] ADDR_STATUS = 8'h10; // read-only state
	// ==========================================================
	// field positions
	localparam int CTRL_NET_BIT = 4; // network path enable
	localparam int SQ_RX_LSB = 4; // rx forced squelch field
	localparam int SQ_ASQ_DIS_BIT = 8; // rx auto squelch disable
	localparam int ST_NET_BIT = 4; // network path initialized
	localparam int ST_OVI_LSB = 8; // rx output valid indicators
	localparam int ST_CAP_BIT = 12; // auto squelch disable capability
	// ==========================================================
	// reset values and fill patterns
	localparam logic [3:0] RST_ENABLES = 4'h0;
	localparam logic RST_FLAG = 1'b0;
	localparam logic [7:0] REPL_PATTERN = 8'h5a; // neutral replacement byte
	localparam logic [7:0] IDLE_BYTE = 8'h00; // squelched or stuffed slot
	localparam logic ASQ_DIS_CAPABLE = 1'b1;
	// ==========================================================
	// state types
	typedef enum logic {path_deactivated_state, path_initialized_state} cem_path_t;
	typedef enum logic {net_deactivated, net_initialized} cem_net_t;
endpackage

// ===== verification/cem_host_model.sv
// host side model: drives the host lanes toward the mux with counting bytes
// assumes the bench gives clk, rst and a per-lane presence mask
`timescale 1ns/1ps
`default_nettype none
module cem_host_model
	import cem_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, active high
	input wire logic [cem_pkg::NUM_PATHS-1:0] lane_on, // host signal present
	output logic [cem_pkg::NET_W-1:0] tx_host_data, // lanes toward the device
	output logic [cem_pkg::NUM_PATHS-1:0] tx_host_valid // sample present
);
	import cem_pkg::*;
	logic [5:0] cnt_reg; // one shared count
	// ==========================================================
	// lane source
	// one count for all lanes keeps them at one rate; absent lanes keep moving too,
	// so a stale byte cannot pass for a fresh one unless it is a multiple of 64 cycles old
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 6'h00;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end
	// lane index sits in the top bits, so a swapped slot shows at once
	always_comb begin
		for (int i = 0; i < NUM_PATHS; i++) begin
			tx_host_data[8*i +: 8] = {i[1:0], cnt_reg};
		end
	end
	assign tx_host_valid = lane_on;
endmodule
`default_nettype wire

// ===== verification/cem_mux_ctrl_tb_top.sv
// self-checking bench for the client encapsulation mux
// assumes the host model drives tx lanes; bench drives registers and rx side
`timescale 1ns/1ps
`default_nettype none
module cem_mux_ctrl_tb_top;
	import cem_pkg::*;
	logic clk, rst, reg_we, reg_re, loss;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, txd, txn, rxn, rxh, d;
	logic [3:0] tv, lane_on, stf, sq, rxs, fail, rv, ovi, rsq;
	int miscompares = 0;
	int tests_run = 0;
	cem_host_model i_cem_host_model (.clk(clk), .rst(rst), .lane_on(lane_on),
		.tx_host_data(txd), .tx_host_valid(tv));
	cem_mux_ctrl i_cem_mux_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.tx_host_data(txd), .tx_host_valid(tv), .tx_net_data(txn), .tx_net_stuff(stf),
		.tx_net_squelch(sq), .rx_net_data(rxn), .rx_net_stuff(rxs),
		.loss_of_network_signal(loss), .rx_host_fail(fail), .rx_host_data(rxh),
		.rx_host_valid(rv), .rx_output_valid_indicator(ovi), .rx_host_squelch(rsq));
	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// the run needs well under a thousand cycles; double that means a hang
	initial begin
		#(50 * 2000);
		miscompares++;
		complete_run();
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// write, then wait out enable-to-state and state-to-output lag
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_we <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	// rx side inputs land one edge later, outputs one more
	task automatic rx_in(input logic l, input logic [3:0] f, input logic [3:0] s);
		@(posedge clk);
		loss <= l;
		fail <= f;
		rxs <= s;
		repeat (2) @(negedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{rst, reg_we, reg_re, loss, reg_addr, reg_wdata} = {4'h8, 40'h0};
		{lane_on, rxs, fail, rxn} = {12'hf00, 32'hc3b2a190};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(32'(stf), 32'hf);
		chk(32'(rsq), 32'hf);
		rd(ADDR_STATUS, 32'h1000);
		rd(8'h14, 32'h0);
		// network alone, no host path up
		wr(ADDR_CTRL, 32'h10);
		rd(ADDR_STATUS, 32'h1010);
		chk(32'(stf), 32'hf);
		wr(ADDR_CTRL, 32'h1f);
		d = txd;
		@(negedge clk);
		chk(txn, d);
		rd(ADDR_STATUS, 32'h1f1f);
		chk(rxh, 32'hc3b2a190);
		// lane 2 absent on tx, slot 2 stuffed on rx
		@(posedge clk);
		lane_on <= 4'hb;
		rx_in(1'b0, 4'h0, 4'h4);
		chk(32'(stf), 32'h4);
		chk(32'(sq), 32'h0);
		chk(32'(rv), 32'hb);
		chk(32'(ovi), 32'hf);
		@(posedge clk);
		lane_on <= 4'hf;
		rx_in(1'b0, 4'h0, 4'h0);
		// take path 1 out, the rest keep running
		wr(ADDR_CTRL, 32'h1d);
		d = txd;
		@(negedge clk);
		chk(txn, d & 32'hffff00ff);
		rd(ADDR_STATUS, 32'h1d1d);
		wr(ADDR_CTRL, 32'h1f);
		// auto squelch on loss and on lane fail
		rx_in(1'b1, 4'h0, 4'h0);
		chk(32'(rsq), 32'hf);
		rx_in(1'b0, 4'h2, 4'h0);
		chk(32'(ovi), 32'hd);
		rx_in(1'b1, 4'h3, 4'h0);
		chk(32'(stf), 32'h0);
		wr(ADDR_SQUELCH, 32'h100);
		chk(32'(ovi), 32'hf);
		wr(ADDR_SQUELCH, 32'h0);
		wr(ADDR_RX_REPL, 32'h1);
		chk(32'(rxh[7:0]), 32'h5a);
		chk(32'(ovi), 32'h1);
		wr(ADDR_SQUELCH, 32'h10);
		chk(32'(ovi), 32'h0);
		rx_in(1'b0, 4'h0, 4'h0);
		// tx replacement, then forced squelch on top
		wr(ADDR_TX_REPL, 32'h9);
		chk(32'(txn[31:24]), 32'h5a);
		chk(32'(txn[7:0]), 32'h5a);
		wr(ADDR_SQUELCH, 32'h9);
		chk(32'(sq), 32'h9);
		chk(32'(stf), 32'h9);
		chk(32'(txn[31:24]), 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
